// ---- pkg/hrb_pkg.sv ----
// constants, register map and state codes of the harmonic ratio blocking stages
package hrb_pkg;
  // ***********************************************
  // clock and time base
  // ***********************************************
  localparam int CLK_HZ = 50_000_000; // reference clock rate
  localparam int DLY_UNIT_MS = 10; // delay counter resolution in ms
  localparam int DLY_UNIT_CYC = CLK_HZ / 1000 * DLY_UNIT_MS; // cycles per delay unit
  // ***********************************************
  // setting ranges (percent and delay units)
  // ***********************************************
  localparam logic [6:0] PCT_SCALE = 7'h64; // 100 percent
  localparam logic [6:0] THR_MIN = 7'h0a; // 10 percent
  localparam logic [6:0] THR_MAX = 7'h64; // 100 percent
  localparam logic [6:0] THR_RST = 7'h0a; // 10 percent after reset
  localparam logic [14:0] DLY_MIN = 15'h0005; // 0.05 s in 10 ms units
  localparam logic [14:0] DLY_MAX = 15'h7530; // 300.0 s in 10 ms units
  localparam logic [14:0] DLY_RST = 15'h0005; // 0.05 s after reset
  localparam logic [3:0] EVT_EN_RST = 4'hf; // all event enables set
  // ***********************************************
  // event bit positions within one stage
  // ***********************************************
  localparam int EV_START_ON = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  localparam int EV_PER_STAGE = 4;
  // ***********************************************
  // register map: per-stage block at stage*0x20, globals at 0x40
  // ***********************************************
  localparam logic [2:0] REG_THRESHOLD = 3'h0; // +0x00
  localparam logic [2:0] REG_DELAY = 3'h1; // +0x04
  localparam logic [2:0] REG_EVT_EN = 3'h2; // +0x08
  localparam logic [2:0] REG_STATUS = 3'h3; // +0x0c start bit0, trip bit1
  localparam logic [2:0] REG_MEAS_A = 3'h4; // +0x10
  localparam logic [2:0] REG_MEAS_B = 3'h5; // +0x14
  localparam logic [2:0] REG_MEAS_C = 3'h6; // +0x18
  localparam logic [2:0] REG_FAULT = 3'h7; // +0x1c peak[15:0], elapsed[23:16]
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h44;
  localparam int FAULT_ELAPSED_DELAY_PERCENT_LSB = 16;
  // ***********************************************
  // divider sequencer states
  // ***********************************************
  typedef enum logic [4:0] {
    HRB_IDLE = 5'b00001,
    HRB_LOAD = 5'b00010,
    HRB_RUN = 5'b00100,
    HRB_STORE = 5'b01000,
    HRB_EVAL = 5'b10000
  } hrb_state_e;
endpackage

// ---- design/hrb_stage.sv ----
// inrush and overexcitation harmonic ratio stages with wishbone registers
// Summary of operation
// [R1] inrush: second harmonic over fundamental, percent
// [R2] overexcitation: fifth harmonic over fundamental, percent
// [R3] start when any phase ratio exceeds threshold
// [R4] trip after definite delay while start holds
// [R5] threshold 10..100 percent, reset 10
// [R6] delay 0.05..300 s, reset 0.05
// [R7] four event enables, default on, gate logging
// [R8] inrush per-phase measured ratios readable
// [R9] overexcitation per-phase measured ratios readable
// [R10] record peak ratio of each fault
// [R11] record elapsed delay percent, 100 means trip
// [R12] start and trip offered as blocking outputs
// [R13] blocked stages need delay over 60 ms
// [R14] start-only blocking ignores trip delay
// [R15] ratio gone: drop start, trip, clear timer
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module hrb_stage #(
  parameter int MAG_W = 16, // width of harmonic magnitudes
  parameter int RAT_W = 16, // width of a ratio in percent
  parameter int UNIT_CYC = hrb_pkg::DLY_UNIT_CYC // cycles per 10 ms delay unit
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // harmonic magnitudes from the measurement front end
  input wire logic meas_tick_i,
  input wire logic [MAG_W-1:0] fund_a_i,
  input wire logic [MAG_W-1:0] fund_b_i,
  input wire logic [MAG_W-1:0] fund_c_i,
  input wire logic [MAG_W-1:0] second_a_i,
  input wire logic [MAG_W-1:0] second_b_i,
  input wire logic [MAG_W-1:0] second_c_i,
  input wire logic [MAG_W-1:0] fifth_a_i,
  input wire logic [MAG_W-1:0] fifth_b_i,
  input wire logic [MAG_W-1:0] fifth_c_i,
  // blocking signals, index 0 inrush, 1 overexcitation
  output logic [1:0] start_o,
  output logic [1:0] trip_o,
  // interrupt
  output logic irq_o
);
  // ***********************************************
  // declarations
  // ***********************************************
  localparam int NUM_W = MAG_W + 7; // numerator: value times 100
  localparam int NJOB = 8; // six ratios plus two elapsed figures
  localparam int NEV = 2 * hrb_pkg::EV_PER_STAGE;
  localparam int UNIT_W = $clog2(UNIT_CYC + 1);
  localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYC - 1);
  localparam logic [RAT_W-1:0] RAT_SAT = {RAT_W{1'b1}};
  localparam logic [2:0] JOB_LAST = 3'h7;
  localparam logic [2:0] JOB_EDLY0 = 3'h6; // first elapsed-delay job

  logic [MAG_W-1:0] fund [3]; // fundamental per phase
  logic [MAG_W-1:0] harm [2][3]; // harmonic per stage and phase
  logic [RAT_W-1:0] ratio [2][3]; // measured ratios per stage and phase
  logic [RAT_W-1:0] elapsed_delay_percent_live [2]; // live elapsed delay percent
  logic [6:0] thr [2]; // threshold setting
  logic [14:0] dly [2]; // delay setting in 10 ms units
  logic [3:0] evt_en [2]; // event enables
  logic [14:0] cnt [2]; // running delay timer
  logic [RAT_W-1:0] peak [2]; // highest ratio of the running fault
  logic [RAT_W-1:0] rec_peak [2]; // recorded peak of the last fault
  logic [7:0] rec_elapsed_delay_percent [2]; // recorded elapsed percent of the last fault
  logic [NEV-1:0] ev_pulse; // one-cycle events, stage*4+event
  logic [NEV-1:0] irq_stat; // sticky event bits
  logic [NEV-1:0] irq_mask; // interrupt enables
  logic [UNIT_W-1:0] unit_div; // 10 ms divider
  logic unit_en; // one pulse per 10 ms

  hrb_pkg::hrb_state_e state; // divider sequencer
  logic [2:0] job; // current divide job
  logic [NUM_W-1:0] num_sh; // numerator being shifted out
  logic [MAG_W-1:0] den; // divisor
  logic [MAG_W:0] rem; // partial remainder
  logic [NUM_W-1:0] quo; // quotient
  logic [4:0] bit_cnt; // bits left in the division
  logic [MAG_W-1:0] next_den;
  logic [NUM_W-1:0] next_num;
  logic [MAG_W:0] rem_sh;
  logic [RAT_W-1:0] quo_sat;
  logic eval_en; // all ratios refreshed this cycle

  logic acc; // new bus request this cycle
  logic wr; // write strobe
  logic [31:0] bmask; // byte-lane mask from sel
  logic [31:0] rdata;
  logic s_sel; // stage addressed by bit 5
  logic [2:0] r_idx; // register within stage block

  assign fund[0] = fund_a_i;
  assign fund[1] = fund_b_i;
  assign fund[2] = fund_c_i;
  assign harm[0][0] = second_a_i; // [R1]
  assign harm[0][1] = second_b_i; // [R1]
  assign harm[0][2] = second_c_i; // [R1]
  assign harm[1][0] = fifth_a_i; // [R2]
  assign harm[1][1] = fifth_b_i; // [R2]
  assign harm[1][2] = fifth_c_i; // [R2]

  // ***********************************************
  // 10 ms time base
  // ***********************************************
  // divider makes the one-cycle enable that paces the delay timers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      unit_div <= '0;
      unit_en <= 1'b0;
    end
    else if (unit_div == UNIT_LAST)
    begin
      unit_div <= '0;
      unit_en <= 1'b1;
    end
    else
    begin
      unit_div <= unit_div + 1'b1;
      unit_en <= 1'b0;
    end
  end

  // ***********************************************
  // shared divider: value*100/base, one job at a time
  // ***********************************************
  // operand select for the job about to load
  always_comb
  begin
    next_num = '0;
    next_den = '0;
    if (job >= JOB_EDLY0)
    begin
      // elapsed delay percent of stage job-6
      next_num = NUM_W'(cnt[job[0]] * hrb_pkg::PCT_SCALE); // [R11]
      next_den = MAG_W'(dly[job[0]]);
    end
    else
    begin
      // job 0..2 inrush phases, 3..5 overexcitation phases
      next_num = NUM_W'(harm[job >= 3'h3][2'((job >= 3'h3) ? job - 3'h3 : job)]
        * hrb_pkg::PCT_SCALE); // [R1] [R2]
      next_den = fund[2'((job >= 3'h3) ? job - 3'h3 : job)];
    end
    rem_sh = {rem[MAG_W-1:0], num_sh[NUM_W-1]};
    quo_sat = (quo > NUM_W'(RAT_SAT)) ? RAT_SAT : quo[RAT_W-1:0];
  end

  // sequencer; one pass per measurement tick, a tick while busy is dropped
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= hrb_pkg::HRB_IDLE;
      job <= '0;
      num_sh <= '0;
      den <= '0;
      rem <= '0;
      quo <= '0;
      bit_cnt <= '0;
      eval_en <= 1'b0;
    end
    else
    begin
      eval_en <= 1'b0;
      case (state)
        hrb_pkg::HRB_IDLE:
        begin
          job <= '0;
          if (meas_tick_i)
            state <= hrb_pkg::HRB_LOAD;
        end
        hrb_pkg::HRB_LOAD:
        begin
          num_sh <= next_num;
          den <= next_den;
          rem <= '0;
          quo <= '0;
          bit_cnt <= 5'(NUM_W);
          state <= hrb_pkg::HRB_RUN;
        end
        hrb_pkg::HRB_RUN:
        begin
          // restoring division, one quotient bit per cycle
          num_sh <= {num_sh[NUM_W-2:0], 1'b0};
          if (rem_sh >= {1'b0, den})
          begin
            rem <= rem_sh - {1'b0, den};
            quo <= {quo[NUM_W-2:0], 1'b1};
          end
          else
          begin
            rem <= rem_sh;
            quo <= {quo[NUM_W-2:0], 1'b0};
          end
          bit_cnt <= bit_cnt - 1'b1;
          if (bit_cnt == 5'h01)
            state <= hrb_pkg::HRB_STORE;
        end
        hrb_pkg::HRB_STORE:
        begin
          job <= job + 1'b1;
          state <= (job == JOB_LAST) ? hrb_pkg::HRB_EVAL : hrb_pkg::HRB_LOAD;
        end
        hrb_pkg::HRB_EVAL:
        begin
          eval_en <= 1'b1;
          state <= hrb_pkg::HRB_IDLE;
        end
        default: state <= hrb_pkg::HRB_IDLE;
      endcase
    end
  end

  // result store; zero fundamental reads as zero ratio, not saturation
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ratio <= '{default: '0};
      elapsed_delay_percent_live <= '{default: '0};
    end
    else if (state == hrb_pkg::HRB_STORE)
    begin
      if (job >= JOB_EDLY0)
        elapsed_delay_percent_live[job[0]] <= quo_sat; // [R11]
      else if (job >= 3'h3)
        ratio[1][2'(job - 3'h3)] <= (den == '0) ? '0 : quo_sat; // [R2] [R9]
      else
        ratio[0][2'(job)] <= (den == '0) ? '0 : quo_sat; // [R1] [R8]
    end
  end

  // ***********************************************
  // the two stages
  // ***********************************************
  for (genvar s = 0; s < 2; s++)
  begin : g_stage
    logic over; // some phase above threshold
    logic [RAT_W-1:0] ph_max; // largest phase ratio now
    assign over = (ratio[s][0] > RAT_W'(thr[s])) || (ratio[s][1] > RAT_W'(thr[s]))
      || (ratio[s][2] > RAT_W'(thr[s])); // [R3]
    assign ph_max = (ratio[s][0] > ratio[s][1])
      ? ((ratio[s][0] > ratio[s][2]) ? ratio[s][0] : ratio[s][2])
      : ((ratio[s][1] > ratio[s][2]) ? ratio[s][1] : ratio[s][2]);

    // start follows the comparison on each refresh; timer runs under it
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
      begin
        start_o[s] <= 1'b0;
        trip_o[s] <= 1'b0;
        cnt[s] <= '0;
      end
      else
      begin
        if (eval_en)
          start_o[s] <= over; // [R3] [R12] [R15]
        if (!start_o[s])
          cnt[s] <= '0; // [R15]
        else if (unit_en && cnt[s] < dly[s])
          cnt[s] <= cnt[s] + 1'b1; // [R4]
        // trip only while start holds, so the start falling drops it too
        trip_o[s] <= start_o[s] && (cnt[s] >= dly[s]); // [R4] [R12] [R15]
      end
    end

    // fault record: peak while start is up, latched with elapsed at release
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
      begin
        peak[s] <= '0;
        rec_peak[s] <= '0;
        rec_elapsed_delay_percent[s] <= '0;
      end
      else if (eval_en)
      begin
        if (over && !start_o[s])
          peak[s] <= ph_max; // [R10]
        else if (over && ph_max > peak[s])
          peak[s] <= ph_max; // [R10]
        if (start_o[s] && !over)
        begin
          rec_peak[s] <= peak[s]; // [R10]
          rec_elapsed_delay_percent[s] <= trip_o[s] ? 8'(hrb_pkg::PCT_SCALE)
            : ((elapsed_delay_percent_live[s] > RAT_W'(hrb_pkg::PCT_SCALE))
            ? 8'(hrb_pkg::PCT_SCALE) : elapsed_delay_percent_live[s][7:0]); // [R11]
        end
      end
    end

    // edge events, each gated by its enable
    assign ev_pulse[s*4 + hrb_pkg::EV_START_ON] = evt_en[s][hrb_pkg::EV_START_ON]
      && eval_en && over && !start_o[s]; // [R7]
    assign ev_pulse[s*4 + hrb_pkg::EV_START_OFF] = evt_en[s][hrb_pkg::EV_START_OFF]
      && eval_en && !over && start_o[s]; // [R7]
    assign ev_pulse[s*4 + hrb_pkg::EV_TRIP_ON] = evt_en[s][hrb_pkg::EV_TRIP_ON]
      && start_o[s] && (cnt[s] >= dly[s]) && !trip_o[s]; // [R7]
    assign ev_pulse[s*4 + hrb_pkg::EV_TRIP_OFF] = evt_en[s][hrb_pkg::EV_TRIP_OFF]
      && trip_o[s] && !(start_o[s] && (cnt[s] >= dly[s])); // [R7]

    // settings; writes outside the range clamp to the nearest limit
    always_ff @(posedge ref_clk_i)
    begin
      logic [31:0] m;
      m = '0;
      if (!rst_n_i)
      begin
        thr[s] <= hrb_pkg::THR_RST; // [R5]
        dly[s] <= hrb_pkg::DLY_RST; // [R6]
        evt_en[s] <= hrb_pkg::EVT_EN_RST; // [R7]
      end
      else if (wr && !wb_adr_i[6] && s_sel == 1'(s))
      begin
        case (r_idx)
          hrb_pkg::REG_THRESHOLD:
          begin
            m = (32'(thr[s]) & ~bmask) | (wb_dat_i & bmask);
            if (m < 32'(hrb_pkg::THR_MIN))
              thr[s] <= hrb_pkg::THR_MIN; // [R5]
            else if (m > 32'(hrb_pkg::THR_MAX))
              thr[s] <= hrb_pkg::THR_MAX; // [R5]
            else
              thr[s] <= m[6:0];
          end
          hrb_pkg::REG_DELAY:
          begin
            m = (32'(dly[s]) & ~bmask) | (wb_dat_i & bmask);
            if (m < 32'(hrb_pkg::DLY_MIN))
              dly[s] <= hrb_pkg::DLY_MIN; // [R6]
            else if (m > 32'(hrb_pkg::DLY_MAX))
              dly[s] <= hrb_pkg::DLY_MAX; // [R6]
            else
              dly[s] <= m[14:0];
          end
          hrb_pkg::REG_EVT_EN:
            if (wb_sel_i[0])
              evt_en[s] <= wb_dat_i[3:0]; // [R7]
          default: ; // read-only words
        endcase
      end
    end
  end

  // ***********************************************
  // interrupt status and mask
  // ***********************************************
  // write one clears; a new event in the same cycle keeps its bit set
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (wr && wb_adr_i == hrb_pkg::ADR_IRQ_STATUS && wb_sel_i[0])
        irq_stat <= (irq_stat & ~wb_dat_i[NEV-1:0]) | ev_pulse;
      else
        irq_stat <= irq_stat | ev_pulse;
      if (wr && wb_adr_i == hrb_pkg::ADR_IRQ_MASK && wb_sel_i[0])
        irq_mask <= wb_dat_i[NEV-1:0];
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ***********************************************
  // wishbone slave
  // ***********************************************
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;
  assign s_sel = wb_adr_i[5];
  assign r_idx = wb_adr_i[4:2];
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // read mux; unmapped words answer zero
  always_comb
  begin
    rdata = '0;
    if (wb_adr_i == hrb_pkg::ADR_IRQ_STATUS)
      rdata = 32'(irq_stat);
    else if (wb_adr_i == hrb_pkg::ADR_IRQ_MASK)
      rdata = 32'(irq_mask);
    else if (!wb_adr_i[6] && !wb_adr_i[7])
    begin
      case (r_idx)
        hrb_pkg::REG_THRESHOLD: rdata = 32'(thr[s_sel]);
        hrb_pkg::REG_DELAY: rdata = 32'(dly[s_sel]);
        hrb_pkg::REG_EVT_EN: rdata = 32'(evt_en[s_sel]);
        hrb_pkg::REG_STATUS: rdata = 32'({trip_o[s_sel], start_o[s_sel]});
        hrb_pkg::REG_MEAS_A: rdata = 32'(ratio[s_sel][0]); // [R8] [R9]
        hrb_pkg::REG_MEAS_B: rdata = 32'(ratio[s_sel][1]); // [R8] [R9]
        hrb_pkg::REG_MEAS_C: rdata = 32'(ratio[s_sel][2]); // [R8] [R9]
        hrb_pkg::REG_FAULT:
          rdata = (32'(rec_elapsed_delay_percent[s_sel]) << hrb_pkg::FAULT_ELAPSED_DELAY_PERCENT_LSB)
            | 32'(rec_peak[s_sel]); // [R10] [R11]
        default: rdata = '0;
      endcase
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i)
        wb_dat_o <= rdata;
    end
  end
endmodule

// ---- verification/hrb_consumer_model.sv ----
// model of a downstream stage that is blocked by the inrush start signal
`timescale 1ns/100ps
module hrb_consumer_model #(
  parameter int DLY_CYC = 250 // own trip delay, well above the blocking window
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // own fault and blocking input
  input wire logic fault_i,
  input wire logic block_i,
  // own trip
  output logic trip_o
);
  // ****************************************
  // definite delay, held off while blocked
  // ****************************************
  int cnt; // cycles of unblocked fault
  // counter clears while blocked, so a block that comes late still wins
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !fault_i || block_i)
    begin
      cnt <= 0;
      trip_o <= 1'b0;
    end
    else if (cnt >= DLY_CYC)
      trip_o <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule

// ---- verification/hrb_stage_chk.sv ----
// concurrent checks on the ports of the harmonic ratio stages
`timescale 1ns/100ps
module hrb_stage_chk #(
  parameter int UNIT_CYC = 10 // cycles per delay unit
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // measurement and blocking
  input wire logic meas_tick_i,
  input wire logic [1:0] start_o,
  input wire logic [1:0] trip_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // helper: run length of each start
  // ****************************************
  int run0; // cycles inrush start has stood
  int run1; // cycles overexcitation start has stood
  // shortest legal delay is five units, so trip needs a long run
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      run0 <= 0;
      run1 <= 0;
    end
    else
    begin
      run0 <= start_o[0] ? run0 + 1 : 0;
      run1 <= start_o[1] ? run1 + 1 : 0;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_ack_one_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_dat_with_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved without ack");
  // eight 25-cycle jobs, eval, then the start register: seen 203 edges after the tick
  a_start_at_eval: assert property ($changed(start_o) |->
    $past(meas_tick_i, 203))
    else $error("start changed outside a pass result");
  a_trip_wait_inrush: assert property ($rose(trip_o[0]) |-> run0 >= 4 * UNIT_CYC)
    else $error("inrush trip before delay");
  a_trip_wait_overex: assert property ($rose(trip_o[1]) |-> run1 >= 4 * UNIT_CYC)
    else $error("overexcitation trip before delay");
  a_trip_drop_inrush: assert property ($fell(start_o[0]) |=> !trip_o[0])
    else $error("inrush trip kept after start fell");
  a_trip_drop_overex: assert property ($fell(start_o[1]) |=> !trip_o[1])
    else $error("overexcitation trip kept after start fell");
  a_trip_needs_start: assert property ((trip_o & ~start_o & ~$past(start_o)) == 2'b00)
    else $error("trip without start");
endmodule
bind hrb_stage hrb_stage_chk #(.UNIT_CYC(UNIT_CYC)) u_chk (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .meas_tick_i(meas_tick_i),
  .start_o(start_o),
  .trip_o(trip_o)
);

// ---- verification/hrb_stage_tb.sv ----
// self-checking bench for the harmonic ratio stages
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module hrb_stage_tb;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic meas_tick_i = 1'b0;
  logic [15:0] fund [3] = '{default: 16'h0000}; // fundamentals a, b, c
  logic [15:0] sec [3] = '{default: 16'h0000}; // second harmonics
  logic [15:0] fif [3] = '{default: 16'h0000}; // fifth harmonics
  logic [1:0] start_o;
  logic [1:0] trip_o;
  logic irq_o;
  logic blk_fault = 1'b0; // fault seen by the downstream stage
  logic blk_trip;
  logic [31:0] rd; // last read word
  int failures = 0;
  int total_checks = 0;
  // short delay unit keeps the run brief
  hrb_stage #(.UNIT_CYC(10)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_tick_i(meas_tick_i),
    .fund_a_i(fund[0]), .fund_b_i(fund[1]), .fund_c_i(fund[2]),
    .second_a_i(sec[0]), .second_b_i(sec[1]), .second_c_i(sec[2]),
    .fifth_a_i(fif[0]), .fifth_b_i(fif[1]), .fifth_c_i(fif[2]),
    .start_o(start_o), .trip_o(trip_o), .irq_o(irq_o));
  hrb_consumer_model u_blk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .fault_i(blk_fault), .block_i(start_o[0]), .trip_o(blk_trip));
  always #10 ref_clk_i = ~ref_clk_i;
  // ****************************************
  // shared tasks
  // ****************************************
  // one classic cycle; request held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      failures++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    `CHK(rd, exp)
  endtask
  // one tick, then wait past the pass result
  task automatic run_pass();
    @(posedge ref_clk_i);
    meas_tick_i <= 1'b1;
    @(posedge ref_clk_i);
    meas_tick_i <= 1'b0;
    repeat (215) @(posedge ref_clk_i);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(8'h00, 32'(hrb_pkg::THR_RST));
    rd_chk(8'h20, 32'(hrb_pkg::THR_RST));
    rd_chk(8'h04, 32'(hrb_pkg::DLY_RST));
    rd_chk(8'h28, 32'(hrb_pkg::EVT_EN_RST));
    rd_chk(8'h4c, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_clamp();
    wb_xfer(1'b1, 8'h00, 32'h05);
    rd_chk(8'h00, 32'h0a);
    wb_xfer(1'b1, 8'h20, 32'hc8);
    rd_chk(8'h20, 32'h64);
    wb_xfer(1'b1, 8'h04, 32'h0);
    rd_chk(8'h04, 32'h05);
    wb_xfer(1'b1, 8'h24, 32'h7fff);
    rd_chk(8'h24, 32'h7530);
    wb_xfer(1'b1, 8'h20, 32'h0a);
    wb_xfer(1'b1, 8'h24, 32'h05);
    $display("test clamp done");
  endtask
  // fault on both stages; start-on logging off for inrush
  task automatic t_start();
    wb_xfer(1'b1, 8'h08, 32'he);
    fund <= '{16'h03e8, 16'h03e8, 16'h03e8};
    sec <= '{16'h009b, 16'h0032, 16'h0000};
    fif <= '{16'h0000, 16'h0000, 16'h012c};
    blk_fault <= 1'b1;
    run_pass();
    `CHK(start_o, 2'b11)
    `CHK(trip_o, 2'b00)
    rd_chk(8'h10, 32'h0f);
    rd_chk(8'h14, 32'h05);
    rd_chk(8'h18, 32'h00);
    rd_chk(8'h30, 32'h00);
    rd_chk(8'h38, 32'h1e);
    repeat (60) @(posedge ref_clk_i);
    `CHK(trip_o, 2'b11)
    `CHK(blk_trip, 1'b0)
    rd_chk(8'h0c, 32'h3);
    rd_chk(8'h40, 32'h54);
    `CHK(irq_o, 1'b0)
    wb_xfer(1'b1, 8'h44, 32'h04);
    repeat (3) @(posedge ref_clk_i);
    `CHK(irq_o, 1'b1)
    wb_xfer(1'b1, 8'h40, 32'h04);
    repeat (3) @(posedge ref_clk_i);
    `CHK(irq_o, 1'b0)
    $display("test start and trip done");
  endtask
  // ratio exactly at threshold must release
  task automatic t_drop();
    sec <= '{16'h0064, 16'h0000, 16'h0000};
    fif <= '{16'h0000, 16'h0000, 16'h0000};
    blk_fault <= 1'b0;
    run_pass();
    `CHK(start_o, 2'b00)
    `CHK(trip_o, 2'b00)
    wb_xfer(1'b0, 8'h1c, 32'h0);
    `CHK(rd[23:0], 24'h64000f)
    wb_xfer(1'b0, 8'h3c, 32'h0);
    `CHK(rd[23:0], 24'h64001e)
    rd_chk(8'h40, 32'hfa);
    $display("test release done");
  endtask
  // fault that clears before a long delay ends; the peak grows between passes
  task automatic t_part();
    wb_xfer(1'b1, 8'h04, 32'h64);
    sec <= '{16'h00c8, 16'h0000, 16'h0000};
    run_pass();
    `CHK(start_o[0], 1'b1)
    sec <= '{16'h012c, 16'h0000, 16'h0000};
    run_pass();
    `CHK(trip_o[0], 1'b0)
    sec <= '{16'h0000, 16'h0000, 16'h0000};
    run_pass();
    `CHK(start_o[0], 1'b0)
    wb_xfer(1'b0, 8'h1c, 32'h0);
    `CHK(rd[15:0], 16'h001e)
    // about 38 units of 100 had run; the divider phase moves it by one
    `CHK(rd[23:16] >= 8'h25 && rd[23:16] <= 8'h28, 1'b1)
    $display("test partial fault done");
  endtask
  // ****************************************
  // closing and sequence
  // ****************************************
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // the run needs about 1250 cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_clamp();
    t_start();
    t_drop();
    t_part();
    end_sim();
  end
endmodule
